// [bench/sdram_core_assertions.sv]
module sdram_core_checker #(
    parameter int REFRESH_INTERVAL = 8,
    parameter int WRITE_FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cke,
    input wire sdram_pkg::cmd_pins_t command,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [sdram_pkg::ADDR_W-1:0] addr,
    input wire logic [sdram_pkg::MASK_W-1:0] dqm,
    input wire logic [sdram_pkg::DATA_W-1:0] dq_in,
    input wire logic [sdram_pkg::DATA_W-1:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic write_buffer_ready,
    input wire logic power_down,
    input wire logic self_refresh,
    input wire logic [sdram_pkg::ROW_W-1:0] refresh_row
);
    timeunit 1ns;
    timeprecision 1ps;
    import sdram_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_suspend_hold: assert property (
        (!$past(cke) && !power_down && !self_refresh) |=> $stable(dq_out) && $stable(dq_oe_n))
        else $error("output moved while clock suspended");
    a_pd_entry: assert property (
        $rose(power_down) |-> $past(!cke) && $past(cke, 2)
            && $past(command.cs_n || command == 4'h7))
        else $error("power-down entered without cke fall and idle command");
    a_pd_exit: assert property (
        ($rose(cke) && power_down) |-> ##1 power_down[*2] ##1 !power_down)
        else $error("power-down exit timing wrong");
    a_sr_exit: assert property (
        ($rose(cke) && self_refresh) |-> ##1 self_refresh[*2] ##1 !self_refresh)
        else $error("self refresh exit timing wrong");
    a_pd_hold: assert property ((power_down && !cke) |=> power_down)
        else $error("power-down left with cke low");
    a_pd_silent: assert property (power_down |-> dq_oe_n && $stable(dq_out))
        else $error("data output active in power-down");
    a_sr_entry: assert property (
        $rose(self_refresh) |-> $past(!cke) && $past(command) == 4'h1)
        else $error("self refresh entered without refresh command");
    a_read_latency: assert property (
        $fell(dq_oe_n) |-> $past(command, 2) == 4'h5 || $past(command, 3) == 4'h5)
        else $error("first read word not two or three cycles after read");
    a_row_step: assert property (
        $changed(refresh_row) |-> refresh_row == $past(refresh_row) + 13'h1
            && ($past(command) == 4'h1 || $past(self_refresh)))
        else $error("refresh row moved without a refresh");

    c_power_down: cover property ($rose(power_down));
    c_self_refresh: cover property ($rose(self_refresh));
    c_read_word: cover property ($fell(dq_oe_n));
endmodule

bind sdram_core sdram_core_checker #(
    .REFRESH_INTERVAL(REFRESH_INTERVAL),
    .WRITE_FIFO_DEPTH(WRITE_FIFO_DEPTH)
) u_checker (.clk, .rst, .cke, .command, .bank_select_low, .bank_select_high, .addr, .dqm,
    .dq_in, .dq_out, .dq_oe_n, .write_buffer_ready, .power_down, .self_refresh, .refresh_row);

// [bench/sdram_core_bench.sv]
module sdram_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sdram_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cke;
    cmd_pins_t command;
    logic bank_select_low;
    logic bank_select_high;
    logic [ADDR_W-1:0] addr;
    logic [MASK_W-1:0] dqm;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
    logic write_buffer_ready;
    logic power_down;
    logic self_refresh;
    logic [ROW_W-1:0] refresh_row;
    int fail_count = 0;
    int checked = 0;

    always #2.5 clk = ~clk;

    sdram_ctrl_model ctl (.clk(clk), .cke(cke), .command(command),
        .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
        .addr(addr), .dqm(dqm), .dq_in(dq_in));

    sdram_core #(.REFRESH_INTERVAL(8), .WRITE_FIFO_DEPTH(16)) dut (.clk(clk), .rst(rst),
        .cke(cke), .command(command), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .addr(addr), .dqm(dqm), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .write_buffer_ready(write_buffer_ready),
        .power_down(power_down), .self_refresh(self_refresh), .refresh_row(refresh_row));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic logic [8:0] bcol(input logic [8:0] s, input int k, input int n,
        input logic il);
        logic [8:0] m;
        m = 9'(n - 1);
        return il ? ((s & ~m) | ((s ^ 9'(k)) & m)) : ((s & ~m) | ((s + 9'(k)) & m));
    endfunction

    task automatic mode(input logic [2:0] bl, input logic il, input logic [2:0] cl);
        ctl.op(3'h0, 2'h0, {6'h0, cl, il, bl});
    endtask

    task automatic rd(input logic [1:0] b, input logic [8:0] col, input int n,
        input logic il, input logic [2:0] cl, input logic [15:0] pfx);
        ctl.op(3'h5, b, {4'h0, col});
        for (int k = 0; k < n; k++) begin
            repeat (k == 0 ? int'(cl) - 1 : 1) @(posedge clk);
            #1;
            check(dq_out, pfx + 16'(bcol(col, k, n, il)));
            check(dq_oe_n, 1'b0);
        end
        @(posedge clk);
        #1;
        check(dq_oe_n, 1'b1);
    endtask

    task automatic sc_burst();
        ctl.op(3'h3, 2'h1, 13'h0);
        ctl.op(3'h3, 2'h2, 13'h0);
        mode(BL_8, 1'b0, CL_2);
        ctl.wr(2'h1, 9'h0, 8, 16'h1000, 2'h0);
        mode(BL_4, 1'b0, CL_2);
        ctl.wr(2'h2, 9'h4, 4, 16'h2004, 2'h0);
        mode(BL_4, 1'b1, CL_3);
        rd(2'h1, 9'h5, 4, 1'b1, CL_3, 16'h1000);
        mode(BL_8, 1'b0, CL_3);
        rd(2'h1, 9'h5, 8, 1'b0, CL_3, 16'h1000);
        mode(BL_2, 1'b0, CL_2);
        rd(2'h2, 9'h7, 2, 1'b0, CL_2, 16'h2000);
    endtask

    task automatic sc_suspend();
        logic [15:0] seq [5] = '{16'h1005, 16'h1005, 16'h1005, 16'h1006, 16'h1007};
        mode(BL_4, 1'b0, CL_2);
        ctl.op(3'h5, 2'h1, 13'h4);
        @(posedge clk);
        #1;
        check(dq_out, 16'h1004);
        ctl.set_cke(1'b0);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            #1;
            check(dq_out, seq[i]);
            if (i == 1) ctl.set_cke(1'b1);
        end
    endtask

    task automatic sc_stop();
        mode(BL_PAGE, 1'b0, CL_2);
        ctl.op(3'h5, 2'h1, 13'h4);
        ctl.op(3'h6, 2'h1, 13'h0);
        repeat (3) @(posedge clk);
        #1;
        check(dq_oe_n, 1'b1);
    endtask

    task automatic sc_refresh();
        logic [12:0] r;
        ctl.op(3'h2, 2'h0, 13'h400);
        ctl.op(3'h3, 2'h1, 13'h0);
        r = refresh_row;
        ctl.op(3'h1, 2'h0, 13'h0);
        check(refresh_row, r);
        mode(BL_1, 1'b0, CL_2);
        // upper lane masked off, so only the low byte changes
        ctl.wr(2'h1, 9'h4, 1, 16'h55aa, 2'h2);
        ctl.op(3'h5, 2'h1, 13'h404);
        @(posedge clk);
        #1;
        check(dq_out, 16'h10aa);
        repeat (2) @(posedge clk);
        ctl.op(3'h1, 2'h0, 13'h0);
        check(refresh_row, r + 13'h1);
    endtask

    task automatic sc_reset();
        @(posedge clk);
        #1;
        rst = 1'b1;
        #1;
        check(16'({dq_oe_n, power_down, self_refresh, write_buffer_ready}), 16'h9);
        check(refresh_row, 16'h0);
        @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic sc_power();
        @(posedge clk);
        #1;
        ctl.set_cke(1'b0);
        @(posedge clk);
        #1;
        check(power_down, 1'b1);
        ctl.op(3'h5, 2'h1, 13'h4, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        check(dq_oe_n, 1'b1);
        check(power_down, 1'b1);
        ctl.set_cke(1'b1);
        repeat (2) @(posedge clk);
        #1;
        check(power_down, 1'b1);
        @(posedge clk);
        #1;
        check(power_down, 1'b0);
        repeat (2) @(posedge clk);
    endtask

    task automatic sc_selfref();
        logic [12:0] r;
        logic [12:0] d;
        r = refresh_row;
        ctl.op(3'h1, 2'h0, 13'h0, 1'b0);
        check(self_refresh, 1'b1);
        repeat (40) @(posedge clk);
        #1;
        d = refresh_row - r;
        // entry refresh plus one row per 8-cycle interval
        check(16'(d), 16'h6);
        ctl.set_cke(1'b1);
        repeat (3) @(posedge clk);
        #1;
        check(self_refresh, 1'b0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #1;
        check(16'({dq_oe_n, power_down, self_refresh, write_buffer_ready}), 16'h9);
        check(refresh_row, 16'h0);
        rst = 1'b0;
        repeat (2) @(posedge clk);
        sc_burst();
        sc_suspend();
        sc_stop();
        sc_refresh();
        sc_reset();
        sc_power();
        sc_selfref();
        end_of_test();
    end

    // whole run needs well under 1000 cycles
    initial begin
        #20000;
        fail_count++;
        end_of_test();
    end
endmodule

// [bench/sdram_ctrl_model.sv]
module sdram_ctrl_model (
    input wire logic clk,
    output logic cke,
    output sdram_pkg::cmd_pins_t command,
    output logic bank_select_low,
    output logic bank_select_high,
    output logic [sdram_pkg::ADDR_W-1:0] addr,
    output logic [sdram_pkg::MASK_W-1:0] dqm,
    output logic [sdram_pkg::DATA_W-1:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import sdram_pkg::*;

    initial begin
        cke = 1'b1;
        command = 4'hf;
        {bank_select_high, bank_select_low} = 2'h0;
        addr = '0;
        dqm = 2'h3;
        dq_in = '0;
    end

    task automatic set_cke(input logic v);
        cke = v;
    endtask

    // released bank and address pins show the inverse and the command goes to 4'hf, so stale values never look valid
    task automatic op(input logic [2:0] rcw, input logic [1:0] b, input logic [12:0] a,
        input logic ck = 1'b1);
        @(posedge clk);
        #1;
        cke = ck;
        command = {1'b0, rcw};
        {bank_select_high, bank_select_low} = b;
        addr = a;
        @(posedge clk);
        #1;
        command = 4'hf;
        {bank_select_high, bank_select_low} = ~b;
        addr = ~addr;
    endtask

    task automatic wr(input logic [1:0] b, input logic [8:0] col, input int n,
        input logic [15:0] base, input logic [1:0] mk);
        @(posedge clk);
        #1;
        command = 4'h4;
        {bank_select_high, bank_select_low} = b;
        addr = {4'h0, col};
        dqm = mk;
        dq_in = base;
        for (int k = 1; k < n; k++) begin
            @(posedge clk);
            #1;
            command = 4'hf;
            dq_in = base + 16'(k);
        end
        @(posedge clk);
        #1;
        command = 4'hf;
        dqm = 2'h3;
        dq_in = ~dq_in;
        addr = ~addr;
    endtask
endmodule

// [core/burst_col_gen.sv]
module burst_col_gen (
    input wire logic [sdram_pkg::COL_W-1:0] start_col,
    input wire logic [sdram_pkg::COL_W-1:0] count,
    input wire logic [2:0] burst_len,
    input wire logic interleave,
    output logic [sdram_pkg::COL_W-1:0] col
);
    import sdram_pkg::*;

    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] low;

    always_comb begin
        mask = burst_mask(burst_len);
        // full page has no interleaved order, so it always counts up
        if (interleave && burst_len != BL_PAGE) begin
            low = start_col ^ count; // [R11]
        end else begin
            low = COL_W'(start_col + count); // [R11]
        end
        col = (start_col & ~mask) | (low & mask); // [R9]
    end
endmodule

// [core/sdram_core.sv]
// Behaviour
// R1: all pins are sampled on the rising clock edge only.
// R2: each live edge advances the burst counter and output data registers.
// R3: clock-gate sampled low suspends the internal clock from the next cycle.
// R4: while suspended, output data and burst address hold; resume at same point.
// R5: low-power modes are entered only when every bank is idle.
// R6: in low-power modes the clock-gate is asynchronous; its rising level exits.
// R7: in low-power modes all other inputs are ignored.
// R8: controller activates a row before reading or writing that bank.
// R9: bursts start at the addressed column and run the programmed count and order.
// R10: burst length 1, 2, 4, 8 or full page; burst-stop ends early.
// R11: burst order is linear or interleaved per the mode register.
// R12: read latency is two or three cycles per the mode register.
// R13: auto precharge closes the row by itself when the burst ends.
// R14: auto refresh and self refresh; 8192 refreshes each 64 ms.
// R15: four independent banks of 16-bit words.
// R16: two bank-select inputs form a binary bank number.
// R17: controller holds clock-gate low to stay in low power, raises it to leave.
module sdram_core #(
    parameter int REFRESH_INTERVAL = sdram_pkg::REFRESH_INTERVAL_CYC,
    parameter int WRITE_FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cke,
    input wire sdram_pkg::cmd_pins_t command,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [sdram_pkg::ADDR_W-1:0] addr,
    input wire logic [sdram_pkg::MASK_W-1:0] dqm,
    input wire logic [sdram_pkg::DATA_W-1:0] dq_in,
    output logic [sdram_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic write_buffer_ready,
    output logic power_down,
    output logic self_refresh,
    output logic [sdram_pkg::ROW_W-1:0] refresh_row
);
    import sdram_pkg::*;

    localparam int MEM_AW = BANK_W + ROW_W + COL_W;
    localparam logic [REF_TIMER_W-1:0] REF_LAST = REF_TIMER_W'(REFRESH_INTERVAL - 1);

    core_state_t s_r;
    core_state_t s_nxt;
    // one flat array holds all banks; bank number forms the top address bits
    logic [DATA_W-1:0] mem [0:(1 << MEM_AW) - 1]; // [R15]

    cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] gen_col;
    logic [COL_W-1:0] next_cnt;
    logic step_go;
    logic step_rd;
    logic [BANK_W-1:0] step_bank;
    logic [COL_W-1:0] step_col;
    logic burst_done;
    logic all_idle;
    logic push;
    wr_entry_t push_entry;
    logic fifo_out_valid;
    logic fifo_out_ready;
    wr_entry_t fifo_out;

    assign cmd = decode_cmd(command);
    assign bank = {bank_select_high, bank_select_low}; // [R16]
    assign next_cnt = COL_W'(s_r.burst_cnt + 1'b1);
    assign all_idle = (s_r.bank_open == '0) && !s_r.burst_act;
    // full page bursts wrap around the row until stopped
    assign burst_done = (s_r.mode_bl != BL_PAGE) &&
                        (s_r.burst_cnt == burst_mask(s_r.mode_bl)); // [R10]

    burst_col_gen u_col (
        .start_col(s_r.burst_start),
        .count(next_cnt),
        .burst_len(s_r.mode_bl),
        .interleave(s_r.mode_bt),
        .col(gen_col)
    );

    always_comb begin
        s_nxt = s_r;
        step_go = 1'b0;
        step_rd = s_r.burst_rd;
        step_bank = s_r.burst_bank;
        step_col = gen_col;
        s_nxt.cke_s1 = cke;
        s_nxt.cke_s2 = s_r.cke_s1;
        case (s_r.mode)
            PM_POWER_DOWN: begin
                // every pin but the clock-gate is ignored here
                s_nxt.cke_q = 1'b0; // [R7]
                if (s_r.cke_s2) begin
                    s_nxt.mode = PM_RUN; // [R6]
                    s_nxt.cke_q = 1'b1;
                end
            end
            PM_SELF_REFRESH: begin
                s_nxt.cke_q = 1'b0; // [R7]
                if (s_r.ref_timer == REF_LAST) begin
                    s_nxt.ref_timer = '0;
                    s_nxt.ref_row = ROW_W'(s_r.ref_row + 1'b1); // [R14]
                end else begin
                    s_nxt.ref_timer = REF_TIMER_W'(s_r.ref_timer + 1'b1);
                end
                if (s_r.cke_s2) begin
                    s_nxt.mode = PM_RUN; // [R6]
                    s_nxt.cke_q = 1'b1;
                    s_nxt.ref_timer = '0;
                end
            end
            default: begin
                s_nxt.cke_q = cke; // [R3]
                // a low sample at the previous edge freezes this edge entirely
                if (s_r.cke_q) begin // [R4]
                    s_nxt.rd_v = {s_r.rd_v[0], 1'b0};
                    s_nxt.rd_d = {s_r.rd_d[0], DATA_W'(0)};
                    if (s_r.mode_cl == CL_3) begin
                        s_nxt.dq_out = s_r.rd_d[1]; // [R12]
                        s_nxt.dq_oe_n = !s_r.rd_v[1];
                    end else begin
                        s_nxt.dq_out = s_r.rd_d[0]; // [R12]
                        s_nxt.dq_oe_n = !s_r.rd_v[0];
                    end
                    if (s_r.burst_act) begin
                        if (burst_done) begin
                            s_nxt.burst_act = 1'b0;
                            if (s_r.burst_ap) begin
                                s_nxt.bank_open[s_r.burst_bank] = 1'b0; // [R13]
                            end
                        end else begin
                            step_go = 1'b1;
                            s_nxt.burst_cnt = next_cnt; // [R2]
                        end
                    end
                    case (cmd)
                        CMD_ACTIVATE: begin
                            s_nxt.bank_open[bank] = 1'b1;
                            s_nxt.open_row[bank] = addr[ROW_W-1:0];
                        end
                        CMD_READ, CMD_WRITE: begin
                            // the bank's open row is trusted; activation is the controller's job
                            step_go = 1'b1; // [R8]
                            step_rd = (cmd == CMD_READ);
                            step_bank = bank;
                            step_col = addr[COL_W-1:0]; // [R9]
                            s_nxt.burst_act = 1'b1;
                            s_nxt.burst_rd = (cmd == CMD_READ);
                            s_nxt.burst_ap = addr[AP_BIT];
                            s_nxt.burst_bank = bank;
                            s_nxt.burst_start = addr[COL_W-1:0];
                            s_nxt.burst_cnt = '0;
                        end
                        CMD_STOP: begin
                            step_go = 1'b0;
                            s_nxt.burst_act = 1'b0; // [R10]
                        end
                        CMD_PRECHARGE: begin
                            if (addr[AP_BIT]) begin
                                s_nxt.bank_open = '0;
                            end else begin
                                s_nxt.bank_open[bank] = 1'b0;
                            end
                        end
                        CMD_MODE: begin
                            s_nxt.mode_bl = addr[BL_LSB +: 3]; // [R10]
                            s_nxt.mode_bt = addr[BT_BIT]; // [R11]
                            s_nxt.mode_cl = addr[CL_LSB +: 3]; // [R12]
                        end
                        CMD_REFRESH: begin
                            if (all_idle) begin
                                s_nxt.ref_row = ROW_W'(s_r.ref_row + 1'b1); // [R14]
                                if (!cke) begin
                                    s_nxt.mode = PM_SELF_REFRESH; // [R5]
                                    s_nxt.cke_s2 = 1'b0; // [R6]
                                    s_nxt.ref_timer = '0;
                                end
                            end
                        end
                        default: begin
                            // with an open bank a low clock-gate is only a suspend
                            if (!cke && all_idle) begin
                                s_nxt.mode = PM_POWER_DOWN; // [R5]
                                // a stale high left in the synchroniser would end the mode at once
                                s_nxt.cke_s2 = 1'b0; // [R6]
                            end
                        end
                    endcase
                end
            end
        endcase
    end

    always_comb begin
        push = step_go && !step_rd;
        push_entry.bank = step_bank;
        push_entry.row = s_r.open_row[step_bank];
        push_entry.col = step_col;
        push_entry.mask = dqm;
        push_entry.data = dq_in;
    end

    // read word enters the latency pipe at the same edge its column is issued
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= CORE_STATE_RST;
        end else begin
            s_r <= s_nxt; // [R1]
            if (step_go && step_rd) begin
                s_r.rd_v[0] <= 1'b1;
                s_r.rd_d[0] <= mem[{step_bank, s_r.open_row[step_bank], step_col}]; // [R2]
            end
        end
    end

    // write buffer drains one word per live cycle; frozen while suspended
    assign fifo_out_ready = s_r.cke_q && (s_r.mode == PM_RUN);

    sync_fifo #(
        .WIDTH($bits(wr_entry_t)),
        .DEPTH(WRITE_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(write_buffer_ready),
        .in_data(push_entry),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    always_ff @(posedge clk) begin
        if (fifo_out_valid && fifo_out_ready) begin
            for (int b = 0; b < MASK_W; b++) begin
                if (!fifo_out.mask[b]) begin
                    mem[{fifo_out.bank, fifo_out.row, fifo_out.col}][b*LANE_W +: LANE_W]
                        <= fifo_out.data[b*LANE_W +: LANE_W];
                end
            end
        end
    end

    assign dq_out = s_r.dq_out;
    assign dq_oe_n = s_r.dq_oe_n;
    assign power_down = (s_r.mode == PM_POWER_DOWN);
    assign self_refresh = (s_r.mode == PM_SELF_REFRESH);
    assign refresh_row = s_r.ref_row;
endmodule

// [core/sdram_pkg.sv]
package sdram_pkg;

    localparam int BANK_W = 2;
    localparam int BANKS = 4;
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int MASK_W = 2;
    localparam int LANE_W = 8;

    // address pin roles during commands
    localparam int AP_BIT = 10;
    localparam int BL_LSB = 0;
    localparam int BT_BIT = 3;
    localparam int CL_LSB = 4;

    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;

    localparam logic [2:0] MODE_BL_RST = BL_1;
    localparam logic MODE_BT_RST = 1'b0;
    localparam logic [2:0] MODE_CL_RST = CL_2;

    // refresh budget: cycles per window spread evenly, longest time rounds down
    localparam longint REFRESH_WINDOW_MS = 64;
    localparam longint REFRESH_COUNT = 8192;
    localparam longint CLK_PERIOD_PS = 5000;
    localparam int REFRESH_INTERVAL_CYC =
        int'((REFRESH_WINDOW_MS * 64'd1000000000) / (REFRESH_COUNT * CLK_PERIOD_PS));
    localparam int REF_TIMER_W = 16;

    typedef enum logic [2:0] {
        CMD_MODE, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE,
        CMD_WRITE, CMD_READ, CMD_STOP, CMD_NOP
    } cmd_t;

    typedef enum logic [1:0] {PM_RUN, PM_POWER_DOWN, PM_SELF_REFRESH} power_mode_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } cmd_pins_t;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [MASK_W-1:0] mask;
        logic [DATA_W-1:0] data;
    } wr_entry_t;

    typedef struct packed {
        power_mode_t mode;
        logic cke_q;
        logic cke_s1;
        logic cke_s2;
        logic [BANKS-1:0] bank_open;
        logic [BANKS-1:0][ROW_W-1:0] open_row;
        logic burst_act;
        logic burst_rd;
        logic burst_ap;
        logic [BANK_W-1:0] burst_bank;
        logic [COL_W-1:0] burst_start;
        logic [COL_W-1:0] burst_cnt;
        logic [2:0] mode_bl;
        logic mode_bt;
        logic [2:0] mode_cl;
        logic [1:0] rd_v;
        logic [1:0][DATA_W-1:0] rd_d;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe_n;
        logic [REF_TIMER_W-1:0] ref_timer;
        logic [ROW_W-1:0] ref_row;
    } core_state_t;

    localparam core_state_t CORE_STATE_RST = '{
        mode: PM_RUN, dq_oe_n: 1'b1, mode_bl: MODE_BL_RST, mode_bt: MODE_BT_RST,
        mode_cl: MODE_CL_RST, default: '0};

    function automatic cmd_t decode_cmd(input cmd_pins_t p);
        cmd_t c;
        c = CMD_NOP;
        if (!p.cs_n) begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h0: c = CMD_MODE;
                3'h1: c = CMD_REFRESH;
                3'h2: c = CMD_PRECHARGE;
                3'h3: c = CMD_ACTIVATE;
                3'h4: c = CMD_WRITE;
                3'h5: c = CMD_READ;
                3'h6: c = CMD_STOP;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    // low column bits that wrap within one burst
    function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] bl);
        logic [COL_W-1:0] m;
        m = '0;
        case (bl)
            BL_2: m = COL_W'(1);
            BL_4: m = COL_W'(3);
            BL_8: m = COL_W'(7);
            BL_PAGE: m = '1;
            default: m = '0;
        endcase
        return m;
    endfunction

endpackage

// [core/sync_fifo.sv]
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic push;
    logic pop;

    assign in_ready = (s_r.count != (AW+1)'(DEPTH));
    assign out_valid = (s_r.count != '0);
    assign out_data = mem[s_r.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.wr = (s_r.wr == AW'(DEPTH - 1)) ? '0 : AW'(s_r.wr + 1'b1);
        end
        if (pop) begin
            s_nxt.rd = (s_r.rd == AW'(DEPTH - 1)) ? '0 : AW'(s_r.rd + 1'b1);
        end
        if (push && !pop) begin
            s_nxt.count = (AW+1)'(s_r.count + 1'b1);
        end else if (pop && !push) begin
            s_nxt.count = (AW+1)'(s_r.count - 1'b1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[s_r.wr] <= in_data;
        end
    end
endmodule
